// [src/isa_bus_master_cycle_sequencer.sv]
// isa cycle sequencer: reset port, config access, boot rom reads, master tenure
// Functional notes
// - reset-port read resets the controller like hardware reset, transceiver link state kept.
// - reset read never asserts iocs16; a following write there is harmless.
// - config registers reached by writing index pointer then reading data port.
// - boot rom spans 64K, served only with 8-bit cycles, memcs16 never driven.
// - rom read: valid address, ref off, memr on; hold iochrdy low, drive byte. Here a rom read is also only decoded in bus master mode.
// - boot_rom_select pulse lasts three 20 MHz clock cycles.
// - master tenure only in bus master mode; obtain, access, release phases.
// - assert dma request; on acknowledge assert master.
// - wait 3 clocks after master before driving address, command or data.
// - target memory assumed 16-bit; bale, iocs16, memcs16, srdy ignored.
// - release: commands off, 50 ns later float and drop drq, 50 ns master off.
// - address valid one clock before memr asserted.
// - read strobe default 5 clocks, length from read_strobe_length field.
// - read strobe ends only when counter expired and iochrdy high.
// - capture read data at strobe end; commands idle at least two clocks.
// - address and data one clock before memw, data held one clock after.
// - write strobe default 5 clocks from write_strobe_length, stretched by iochrdy low.
// - write gap two clocks when config 2 bit 4 set, else 200 ns.
// - re-request after 2.6 us if lower drq active, else 1.1 us.
// - channel priority 3, 5, 6, 7; channel 3 highest.
`timescale 1ns/1ps
module isa_bus_master_cycle_sequencer #(
  parameter int REREQ_LOW_CYC = isa_seq_pkg::REREQ_LOW_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_port_rd,
  input wire logic reset_port_wr,
  output logic soft_reset_pulse,
  output logic iocs16_n,
  input wire logic ref_n,
  input wire logic memr_n_in,
  input wire logic [23:0] la_in,
  input wire logic [7:0] private_data_bus_in,
  output logic boot_rom_select_n,
  output logic [15:0] rom_addr,
  output logic iochrdy_o,
  output logic iochrdy_oe,
  input wire logic iochrdy_in,
  output logic [15:0] sd_o,
  output logic [15:0] sd_oe,
  input wire logic [15:0] sd_in,
  output logic [3:0] drq,
  input wire logic [3:0] drq_in,
  input wire logic dack_n,
  output logic master_n,
  output logic [23:0] addr_o,
  output logic sbhe_n,
  output logic addr_oe,
  output logic memr_n,
  output logic memw_n,
  output logic cmd_oe
);
  typedef enum {S_IDLE, S_REQ, S_SETTLE, S_SETUP, S_STROBE, S_HOLD, S_GAP,
    S_REL1, S_REL2, S_WAIT} mstate_t;
  typedef enum {B_IDLE, B_CS, B_DRIVE} rstate_t;
  mstate_t ms_q, ms_d;
  rstate_t rs_q;
  logic [3:0] div_q;
  logic tick;
  logic [15:0] cfg_q [isa_seq_pkg::NUM_CFG];
  logic [1:0] index_q;
  logic [7:0] ctrl_q;
  logic [23:0] xaddr_q;
  logic [15:0] xdata_q, rdata_q, cnt_q;
  logic [7:0] rom_base_q, rom_byte_q;
  logic [1:0] rcnt_q;
  logic busy_q, lower_q;
  logic soft_q;
  // apb decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_ctrl = paddr == isa_seq_pkg::OFF_CTRL;
  wire hit_index = paddr == isa_seq_pkg::OFF_INDEX;
  wire hit_cfg = paddr == isa_seq_pkg::OFF_CONFIG_DATA;
  wire hit_xa = paddr == isa_seq_pkg::OFF_XFER_ADDR;
  wire hit_xd = paddr == isa_seq_pkg::OFF_XFER_DATA;
  wire hit_st = paddr == isa_seq_pkg::OFF_STATUS;
  wire hit_rd = paddr == isa_seq_pkg::OFF_RD_DATA;
  wire hit_rb = paddr == isa_seq_pkg::OFF_ROM_BASE;
  wire hit_any = hit_ctrl | hit_index | hit_cfg | hit_xa | hit_xd | hit_st | hit_rd | hit_rb;
  wire master_mode = ctrl_q[isa_seq_pkg::CTRL_MASTER_MODE];
  wire [1:0] chan = ctrl_q[isa_seq_pkg::CTRL_CHAN_HI:isa_seq_pkg::CTRL_CHAN_LO];
  wire go = wr && hit_ctrl && pwdata[isa_seq_pkg::CTRL_GO];
  // channel index 0..3 means drq3, drq5, drq6, drq7; higher index is lower priority
  wire [3:0] lower_mask = 4'hE << chan;
  wire lower_active = |(drq_in & lower_mask);
  wire short_gap = cfg_q[2][isa_seq_pkg::GAP_SHORT_BIT];
  wire [15:0] rd_len = (cfg_q[0] == 16'h0000) ? 16'h0001 : cfg_q[0];
  wire [15:0] wr_len = (cfg_q[1] == 16'h0000) ? 16'h0001 : cfg_q[1];
  wire [15:0] gap_len = short_gap ? 16'(isa_seq_pkg::GAP_SHORT_TICKS)
    : 16'(isa_seq_pkg::GAP_LONG_TICKS);
  wire rom_hit = !master_mode ? 1'b0 : (la_in[23:16] == rom_base_q);
  wire rom_start = rom_hit && ref_n && !memr_n_in;
  wire cnt_done = cnt_q <= 16'h0001;
  wire is_wr = ctrl_q[isa_seq_pkg::CTRL_WRITE];
  assign tick = div_q == 4'(isa_seq_pkg::NET_DIV - 1);
  assign pready = 1'b1;
  assign pslverr = acc && !hit_any;
  always_comb begin
    prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      prdata = {24'h000000, ctrl_q};
    end else if (hit_index) begin
      prdata = {30'h0, index_q};
    end else if (hit_cfg) begin
      prdata = {16'h0000, cfg_q[index_q]};
    end else if (hit_xa) begin
      prdata = {8'h00, xaddr_q};
    end else if (hit_xd) begin
      prdata = {16'h0000, xdata_q};
    end else if (hit_st) begin
      prdata = {28'h0, lower_q, !master_n, busy_q, rs_q != B_IDLE};
    end else if (hit_rd) begin
      prdata = {16'h0000, rdata_q};
    end else if (hit_rb) begin
      prdata = {24'h000000, rom_base_q};
    end
  end
  // network clock enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 4'h0;
    end else begin
      div_q <= tick ? 4'h0 : div_q + 4'h1;
    end
  end
  // reset-port read; link state lives outside this block and ignores this pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= reset_port_rd;
    end
  end
  assign soft_reset_pulse = soft_q;
  // register-cycle responses elsewhere own iocs16; reset and rom cycles never pull it
  assign iocs16_n = 1'b1;
  // registers; soft reset restores them like a hardware reset; writes to the port ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 8'h00;
      index_q <= 2'h0;
      xaddr_q <= 24'h000000;
      xdata_q <= 16'h0000;
      rom_base_q <= 8'h00;
      cfg_q[0] <= isa_seq_pkg::CFG0_RESET;
      cfg_q[1] <= isa_seq_pkg::CFG1_RESET;
      cfg_q[2] <= isa_seq_pkg::CFG2_RESET;
      cfg_q[3] <= isa_seq_pkg::CFG3_RESET;
    end else if (soft_q) begin
      ctrl_q <= 8'h00;
      index_q <= 2'h0;
      xaddr_q <= 24'h000000;
      xdata_q <= 16'h0000;
      rom_base_q <= 8'h00;
      cfg_q[0] <= isa_seq_pkg::CFG0_RESET;
      cfg_q[1] <= isa_seq_pkg::CFG1_RESET;
      cfg_q[2] <= isa_seq_pkg::CFG2_RESET;
      cfg_q[3] <= isa_seq_pkg::CFG3_RESET;
    end else if (wr) begin
      if (hit_ctrl) begin
        // direction latched only on a go write while not busy, so a running tenure keeps it
        ctrl_q <= {pwdata[7:3], ctrl_q[isa_seq_pkg::CTRL_WRITE], 1'b0, pwdata[0]};
        if (go && !busy_q) begin
          ctrl_q[isa_seq_pkg::CTRL_WRITE] <= pwdata[isa_seq_pkg::CTRL_WRITE];
        end
      end else if (hit_index) begin
        index_q <= pwdata[1:0];
      end else if (hit_cfg) begin
        cfg_q[index_q] <= pwdata[15:0];
      end else if (hit_xa) begin
        xaddr_q <= pwdata[23:0];
      end else if (hit_xd) begin
        xdata_q <= pwdata[15:0];
      end else if (hit_rb) begin
        rom_base_q <= pwdata[7:0];
      end
    end
  end
  // boot rom sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_q <= B_IDLE;
      rcnt_q <= 2'h0;
      rom_byte_q <= 8'h00;
    end else if (soft_q) begin
      rs_q <= B_IDLE;
      rcnt_q <= 2'h0;
      rom_byte_q <= 8'h00;
    end else begin
      case (rs_q)
        B_IDLE: begin
          if (rom_start && tick) begin
            rs_q <= B_CS;
            rcnt_q <= 2'h0;
          end
        end
        B_CS: begin
          if (tick) begin
            rcnt_q <= rcnt_q + 2'h1;
            if (rcnt_q == 2'(isa_seq_pkg::ROM_CS_TICKS - 1)) begin
              rom_byte_q <= private_data_bus_in;
              rs_q <= B_DRIVE;
            end
          end
        end
        default: begin
          if (memr_n_in) begin
            rs_q <= B_IDLE;
          end
        end
      endcase
    end
  end
  assign boot_rom_select_n = !(rs_q == B_CS);
  assign rom_addr = la_in[15:0];
  // master sequencer
  always_comb begin
    ms_d = ms_q;
    case (ms_q)
      S_IDLE: begin
        if (go && pwdata[isa_seq_pkg::CTRL_MASTER_MODE] && !busy_q) begin
          ms_d = S_REQ;
        end
      end
      S_REQ: begin
        // taken on a tick so the settle count spans three whole network clocks
        if (tick && !dack_n && ref_n) begin
          ms_d = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (tick && cnt_done) begin
          ms_d = S_SETUP;
        end
      end
      S_SETUP: begin
        if (tick) begin
          ms_d = S_STROBE;
        end
      end
      S_STROBE: begin
        if (tick && cnt_done && iochrdy_in) begin
          ms_d = S_HOLD;
        end
      end
      S_HOLD: begin
        if (tick) begin
          ms_d = S_GAP;
        end
      end
      S_GAP: begin
        if (tick && cnt_done) begin
          ms_d = S_REL1;
        end
      end
      S_REL1: begin
        if (tick && cnt_done) begin
          ms_d = S_REL2;
        end
      end
      S_REL2: begin
        if (tick && cnt_done) begin
          ms_d = S_WAIT;
        end
      end
      S_WAIT: begin
        if (tick && cnt_done) begin
          ms_d = S_IDLE;
        end
      end
      default: ms_d = S_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_q <= S_IDLE;
      cnt_q <= 16'h0000;
      busy_q <= 1'b0;
      lower_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else if (soft_q) begin
      ms_q <= S_IDLE;
      cnt_q <= 16'h0000;
      busy_q <= 1'b0;
      lower_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      ms_q <= ms_d;
      if (ms_q == S_IDLE && ms_d == S_REQ) begin
        busy_q <= 1'b1;
      end else if (ms_q == S_WAIT && ms_d == S_IDLE) begin
        busy_q <= 1'b0;
      end
      if (ms_q == S_REQ && ms_d == S_SETTLE) begin
        cnt_q <= 16'(isa_seq_pkg::MASTER_SETTLE_TICKS);
      end else if (ms_q == S_SETUP && ms_d == S_STROBE) begin
        cnt_q <= is_wr ? wr_len : rd_len;
      end else if (ms_q == S_HOLD && ms_d == S_GAP) begin
        cnt_q <= is_wr ? gap_len : 16'(isa_seq_pkg::GAP_SHORT_TICKS - 1);
      end else if ((ms_q == S_GAP || ms_q == S_REL1) && ms_d != ms_q) begin
        cnt_q <= 16'(isa_seq_pkg::RELEASE_STEP_TICKS);
      end else if (ms_q == S_REL2 && ms_d == S_WAIT) begin
        // adaptive re-request delay counted from master release
        cnt_q <= lower_active ? 16'(REREQ_LOW_CYC)
          : 16'(isa_seq_pkg::REREQ_FAST_TICKS);
        lower_q <= lower_active;
      end else if (tick && cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end
      if (ms_q == S_STROBE && ms_d == S_HOLD && !is_wr) begin
        rdata_q <= sd_in;
      end
    end
  end
  // drq held from request through first release step
  wire req_on = ms_q == S_REQ || ms_q == S_SETTLE || ms_q == S_SETUP || ms_q == S_STROBE
    || ms_q == S_HOLD || ms_q == S_GAP || ms_q == S_REL1;
  wire own = req_on && ms_q != S_REQ;
  wire drive = own && ms_q != S_SETTLE;
  assign drq = req_on ? (4'h1 << chan) : 4'h0;
  assign master_n = !(own || ms_q == S_REL2);
  assign addr_o = xaddr_q;
  assign sbhe_n = 1'b0;
  assign addr_oe = drive;
  assign cmd_oe = drive;
  assign memr_n = !(ms_q == S_STROBE && !is_wr);
  assign memw_n = !(ms_q == S_STROBE && is_wr);
  // rom data on low lanes only; write data held through hold state
  wire rom_drive = rs_q == B_DRIVE;
  wire wdrive = drive && is_wr && (ms_q == S_SETUP || ms_q == S_STROBE || ms_q == S_HOLD);
  assign sd_o = rom_drive ? {8'h00, rom_byte_q} : xdata_q;
  assign sd_oe = rom_drive ? 16'h00FF : (wdrive ? 16'hFFFF : 16'h0000);
  assign iochrdy_o = 1'b0;
  assign iochrdy_oe = rs_q == B_CS || (rom_start && rs_q == B_IDLE);
endmodule

// [src/isa_seq_pkg.sv]
// constants for the isa bus master cycle sequencer
package isa_seq_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INDEX = 8'h04;
  localparam logic [7:0] OFF_CONFIG_DATA = 8'h08;
  localparam logic [7:0] OFF_XFER_ADDR = 8'h0C;
  localparam logic [7:0] OFF_XFER_DATA = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_RD_DATA = 8'h18;
  localparam logic [7:0] OFF_ROM_BASE = 8'h1C;
  // control register bit positions
  localparam int CTRL_MASTER_MODE = 0;
  localparam int CTRL_GO = 1;
  localparam int CTRL_WRITE = 2;
  localparam int CTRL_LAST = 3;
  localparam int CTRL_CHAN_LO = 4;
  localparam int CTRL_CHAN_HI = 5;
  // bus configuration registers
  localparam int NUM_CFG = 4;
  localparam int GAP_SHORT_BIT = 4;
  localparam logic [15:0] CFG0_RESET = 16'h0005;
  localparam logic [15:0] CFG1_RESET = 16'h0005;
  localparam logic [15:0] CFG2_RESET = 16'h0010;
  localparam logic [15:0] CFG3_RESET = 16'h0000;
  // timing at the 20 MHz network clock
  localparam int PCLK_MHZ = 200;
  localparam int NET_MHZ = 20;
  localparam int NET_DIV = PCLK_MHZ / NET_MHZ;
  localparam int ROM_CS_TICKS = 3;
  localparam int MASTER_SETTLE_TICKS = 3;
  localparam int RELEASE_STEP_NS = 50;
  localparam int RELEASE_STEP_TICKS = (RELEASE_STEP_NS * NET_MHZ) / 1000;
  localparam int GAP_SHORT_TICKS = 2;
  localparam int GAP_LONG_NS = 200;
  localparam int GAP_LONG_TICKS = (GAP_LONG_NS * NET_MHZ + 999) / 1000;
  localparam int REREQ_LOW_NS = 2600;
  localparam int REREQ_LOW_TICKS = (REREQ_LOW_NS * NET_MHZ + 999) / 1000;
  localparam int REREQ_FAST_NS = 1100;
  localparam int REREQ_FAST_TICKS = (REREQ_FAST_NS * NET_MHZ + 999) / 1000;
endpackage

// [testbench/isa_host_model.sv]
// dma controller and target memory beyond the master interface
`timescale 1ns/1ps
module isa_host_model (
  input wire logic pclk,
  input wire logic slow,
  input wire logic [15:0] rd_word,
  input wire logic [3:0] drq,
  input wire logic memr_n,
  input wire logic memw_n,
  output logic dack_n,
  output logic rdy,
  output logic [15:0] sd
);
  int ack_q = 0;
  int strb_q = 0;
  initial begin
    dack_n = 1'b1;
    rdy = 1'b1;
    sd = 16'h0000;
  end
  always @(posedge pclk) begin
    ack_q <= (drq == 4'h0) ? 0 : ack_q + 1;
    strb_q <= (memr_n && memw_n) ? 0 : strb_q + 1;
    // own lines are never driven, so they float before ack
    dack_n <= (drq == 4'h0) || (ack_q < (slow ? 9 : 1));
    // slow target outlasts the longest programmed strobe, so every slow strobe stretches
    rdy <= !(slow && !(memr_n && memw_n) && strb_q < 80);
    // changing pattern outside a read strobe, so stale data cannot pass
    sd <= memr_n ? ~sd : rd_word;
  end
endmodule

// [testbench/isa_seq_sva.sv]
// port checks for the isa cycle sequencer
`timescale 1ns/1ps
module isa_seq_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reset_port_rd,
  input wire logic soft_reset_pulse,
  input wire logic iocs16_n,
  input wire logic boot_rom_select_n,
  input wire logic iochrdy_oe,
  input wire logic iochrdy_in,
  input wire logic [15:0] sd_oe,
  input wire logic [3:0] drq,
  input wire logic dack_n,
  input wire logic master_n,
  input wire logic addr_oe,
  input wire logic memr_n,
  input wire logic memw_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] sel_q, idle_q, mst_q;
  wire cmd_idle = memr_n && memw_n;
  // counters keep long spans out of repetitions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 8'h00;
      idle_q <= 8'h00;
      mst_q <= 8'h00;
    end else begin
      sel_q <= boot_rom_select_n ? 8'h00 : sel_q + 8'h01;
      idle_q <= !cmd_idle ? 8'h00 : (idle_q == 8'hFF) ? idle_q : idle_q + 8'h01;
      mst_q <= master_n ? 8'h00 : (mst_q == 8'hFF) ? mst_q : mst_q + 8'h01;
    end
  end
  soft_reset_a: assert property (reset_port_rd |=> soft_reset_pulse)
    else $error("no soft reset");
  no_iocs16_a: assert property (iocs16_n)
    else $error("iocs16 driven");
  low_lane_a: assert property (master_n |-> sd_oe[15:8] == 8'h00)
    else $error("high lanes driven");
  rom_wait_a: assert property (!boot_rom_select_n |-> iochrdy_oe)
    else $error("ready not held low");
  rom_width_a: assert property ($rose(boot_rom_select_n) |-> sel_q == 8'h1E)
    else $error("rom select width");
  ack_master_a: assert property ($fell(master_n) |-> !$past(dack_n) && drq != 4'h0)
    else $error("master without ack");
  settle_a: assert property ($rose(addr_oe) |-> mst_q >= 8'h1E)
    else $error("drive too soon");
  release_a: assert property ($rose(master_n) |-> $past(drq, 5) == 4'h0 && !$past(addr_oe, 5))
    else $error("release order");
  setup_a: assert property ($fell(memr_n) |-> $past(addr_oe, 10))
    else $error("address setup");
  rdy_end_a: assert property ($rose(memr_n) |-> $past(iochrdy_in))
    else $error("strobe ended while not ready");
  gap_a: assert property ($fell(cmd_idle) |-> idle_q >= 8'h14)
    else $error("command gap short");
  hold_a: assert property ($rose(memw_n) |-> (sd_oe == 16'hFFFF) [*8])
    else $error("write data hold");
endmodule
bind isa_bus_master_cycle_sequencer isa_seq_sva u_isa_seq_sva (.pclk, .presetn, .reset_port_rd,
  .soft_reset_pulse, .iocs16_n, .boot_rom_select_n, .iochrdy_oe, .iochrdy_in, .sd_oe, .drq,
  .dack_n, .master_n, .addr_oe, .memr_n, .memw_n);

// [testbench/test_isa_bus_master_cycle_sequencer.sv]
// self-checking bench for the isa cycle sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %0t got %h expected %h", $time, g, e); end end
module test_isa_bus_master_cycle_sequencer;
  localparam int LOW_TICKS = 4;
  localparam logic [15:0] CFG_RST [4] = '{isa_seq_pkg::CFG0_RESET, isa_seq_pkg::CFG1_RESET,
    isa_seq_pkg::CFG2_RESET, isa_seq_pkg::CFG3_RESET};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, slow = 0, dk, host_rdy;
  logic reset_port_rd = 0, reset_port_wr = 0, ref_n = 1, memr_n_in = 1;
  logic pready, pslverr, soft_reset_pulse, iocs16_n, boot_rom_select_n, iochrdy_o, iochrdy_oe;
  logic dack_n, master_n, sbhe_n, addr_oe, memr_n, memw_n, cmd_oe;
  logic [7:0] paddr = 8'h00, private_data_bus_in = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [23:0] la_in = 24'h0, addr_o, maddr, a;
  logic [15:0] rom_addr, sd_o, sd_oe, host_sd, mdata, d, rd_word = 16'h0;
  logic [15:0] exp_cfg [4] = CFG_RST;
  logic [3:0] drq, drq_in = 4'h0, pd = 4'h0, ld;
  int fails = 0, compares = 0, cyc = 0, slen = 0, gap = 0, rel = 0;
  int sq[$], gq[$], rq[$];
  wire rdy_w = host_rdy && !iochrdy_oe;
  wire [15:0] sd_w = (sd_oe & sd_o) | (~sd_oe & host_sd);
  always #2.5 pclk = ~pclk;
  isa_bus_master_cycle_sequencer #(.REREQ_LOW_CYC(LOW_TICKS)) u_isa_bus_master_cycle_sequencer (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .reset_port_rd, .reset_port_wr, .soft_reset_pulse, .iocs16_n, .ref_n, .memr_n_in, .la_in,
    .private_data_bus_in, .boot_rom_select_n, .rom_addr, .iochrdy_o, .iochrdy_oe,
    .iochrdy_in(rdy_w), .sd_o, .sd_oe, .sd_in(sd_w), .drq, .drq_in, .dack_n, .master_n,
    .addr_o, .sbhe_n, .addr_oe, .memr_n, .memw_n, .cmd_oe);
  isa_host_model u_isa_host_model (.pclk, .slow, .rd_word, .drq, .memr_n, .memw_n, .dack_n,
    .rdy(host_rdy), .sd(host_sd));
  // strobe length, first address and data, ack-to-request gap
  always @(posedge pclk) begin
    rel++;
    if (!memr_n || !memw_n) begin
      if (slen == 0) begin
        maddr = addr_o;
        mdata = sd_o;
      end
      slen++;
    end else if (slen != 0) begin
      sq.push_back(slen);
      slen = 0;
      rel = 0;
    end
    gap = (dack_n && !dk) ? 0 : gap + 1;
    if (drq != 4'h0 && pd == 4'h0) begin
      gq.push_back(gap);
      ld = drq;
    end
    if (drq == 4'h0 && pd != 4'h0) rq.push_back(rel);
    pd = drq;
    dk = dack_n;
  end
  always @(posedge pclk) if (++cyc == 20000) begin
    fails++;
    end_sim();
  end
  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cfg_chk();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, isa_seq_pkg::OFF_INDEX, 32'(i));
      apb(1'b0, isa_seq_pkg::OFF_CONFIG_DATA, 32'h0);
      `CHK(rd[15:0], exp_cfg[i])
    end
  endtask
  initial begin
    int w, lo, plo, len, g, eg;
    void'($urandom(78));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cfg_chk();
    apb(1'b0, 8'h20, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    apb(1'b1, isa_seq_pkg::OFF_CTRL, 32'h0000000A);
    repeat (40) @(posedge pclk);
    `CHK(drq, 4'h0)
    for (int i = 0; i < 5; i++) begin
      w = i % 2;
      lo = (i / 2) % 2;
      len = $urandom_range(7, 1);
      a = 24'($urandom);
      d = 16'($urandom);
      slow <= (i == 2 || i == 3);
      rd_word <= ~d;
      drq_in <= lo ? 4'h4 : 4'h1;
      if (i == 3) begin
        // long command gap on one write
        apb(1'b1, isa_seq_pkg::OFF_INDEX, 32'h2);
        apb(1'b1, isa_seq_pkg::OFF_CONFIG_DATA, 32'h0);
      end
      apb(1'b1, isa_seq_pkg::OFF_INDEX, 32'(w));
      apb(1'b1, isa_seq_pkg::OFF_CONFIG_DATA, 32'(len));
      apb(1'b1, isa_seq_pkg::OFF_XFER_ADDR, 32'(a));
      apb(1'b1, isa_seq_pkg::OFF_XFER_DATA, 32'(d));
      apb(1'b1, isa_seq_pkg::OFF_CTRL, 32'h1B | 32'(w << 2));
      do apb(1'b0, isa_seq_pkg::OFF_STATUS, 32'h0); while (rd[1] !== 1'b0);
      `CHK(maddr, a)
      `CHK(sbhe_n, 1'b0)
      `CHK(ld, 4'h2)
      if (w == 1) `CHK(mdata, d)
      else begin
        apb(1'b0, isa_seq_pkg::OFF_RD_DATA, 32'h0);
        `CHK(rd[15:0], ~d)
      end
      len = len * 10;
      g = sq.pop_back();
      if (i == 2 || i == 3) `CHK(g > len, 1'b1)
      else `CHK(g, len)
      eg = (w == 0) ? isa_seq_pkg::GAP_SHORT_TICKS - 1 : isa_seq_pkg::GAP_SHORT_TICKS;
      if (i == 3) eg = isa_seq_pkg::GAP_LONG_TICKS;
      g = rq.pop_back();
      `CHK(g, eg * 10 + 20)
      g = gq.pop_back() - (plo ? LOW_TICKS : isa_seq_pkg::REREQ_FAST_TICKS) * 10;
      if (i > 0) `CHK(g >= 0 && g <= 60, 1'b1)
      plo = lo;
    end
    apb(1'b1, isa_seq_pkg::OFF_ROM_BASE, 32'h5A);
    apb(1'b1, isa_seq_pkg::OFF_CTRL, 32'h1);
    for (int r = 0; r < 2; r++) begin
      a = {8'h5A, 16'($urandom)};
      la_in <= a;
      ref_n <= r[0];
      private_data_bus_in <= a[7:0] ^ 8'hC3;
      memr_n_in <= 1'b0;
      repeat (60) @(posedge pclk);
      `CHK(sd_oe, r ? 16'h00FF : 16'h0000)
      `CHK(iochrdy_oe, 1'b0)
      `CHK(sd_o[7:0] | {8{r == 0}}, r ? a[7:0] ^ 8'hC3 : 8'hFF)
      `CHK(rom_addr, a[15:0])
      memr_n_in <= 1'b1;
      repeat (20) @(posedge pclk);
      `CHK(sd_oe, 16'h0000)
    end
    reset_port_rd <= 1'b1;
    reset_port_wr <= 1'b1;
    @(posedge pclk);
    reset_port_rd <= 1'b0;
    reset_port_wr <= 1'b0;
    repeat (3) @(posedge pclk);
    exp_cfg = CFG_RST;
    cfg_chk();
    end_sim();
  end
endmodule
